//--- design/tla_compare.sv
// Signed limit comparison with hysteresis thresholds
`timescale 1ns/1ps
module tla_compare #(
    parameter int TW = 16,
    parameter int HW = 4
) (
    input  wire logic signed [TW-1:0] temp,
    input  wire logic signed [TW-1:0] high_lim,
    input  wire logic signed [TW-1:0] low_lim,
    input  wire logic        [HW-1:0] hyst,
    output logic                      over_hi,
    output logic                      under_lo,
    output logic                      clear_ok
);
    import tla_pkg::*;
    logic signed [TW+1:0] hyst_s;
    logic signed [TW+1:0] hi_rel;
    logic signed [TW+1:0] lo_rel;
    always_comb begin
        // Hysteresis in whole degrees, scaled to result units
        hyst_s = signed'({{(TW+2-HW){1'b0}}, hyst}) <<< HYST_SHIFT;
        hi_rel = TW'(0) + high_lim - hyst_s;
        lo_rel = TW'(0) + low_lim + hyst_s;
        over_hi  = temp > high_lim;
        under_lo = temp < low_lim;
        clear_ok = (temp < hi_rel) && (temp > lo_rel);
    end
endmodule // tla_compare

//--- design/tla_pkg.sv
// Constants for the temperature limit alert block
package tla_pkg;
    localparam int          TEMP_W        = 16;
    localparam int          HYST_W        = 4;
    localparam int          HYST_SHIFT    = 7;
    localparam logic [7:0]  OFF_HYST      = 8'h14;
    localparam logic [7:0]  OFF_HIGH      = 8'h18;
    localparam logic [7:0]  OFF_LOW       = 8'h1c;
    localparam logic [7:0]  OFF_CTRL      = 8'h20;
    localparam logic [7:0]  OFF_STAT      = 8'h24;
    localparam logic [7:0]  OFF_TEMP      = 8'h28;
    localparam logic [15:0] HIGH_RST      = 16'h2000;
    localparam logic [15:0] LOW_RST       = 16'h0500;
    localparam logic [3:0]  HYST_RST      = 4'h5;
    localparam int          CTRL_MODE_BIT = 0;
    localparam int          CTRL_POL_BIT  = 1;
    localparam int          CTRL_SHDN_BIT = 2;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage

//--- design/tla_top.sv
// Temperature limit alert with AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tla_top #(
    parameter int TW = 16,
    parameter int HW = 4
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic [TW-1:0] temp_value,
    input  wire logic          temp_valid,
    output logic               alert_o,
    output logic               alert_oe_n
);
    import tla_pkg::*;

    logic [TW-1:0] high_r, low_r, temp_r;
    logic [HW-1:0] hyst_r;
    logic          mode_r, pol_r, shdn_r, alert_r, alert_o_r, oe_n_r;
    logic          hreadyout_r, hresp_r;
    logic          wr_pend_r, rd_pend_r;
    logic [7:0]    addr_r;
    logic [31:0]   rdata_r;
    logic          over_hi, under_lo, clear_ok;
    logic          addr_ok, shdn_nxt, rd_done, eval_r;

    assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign hrdata    = rdata_r;
    assign alert_o   = alert_o_r;
    assign alert_oe_n = oe_n_r;

    // Zero wait states, response always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            rd_pend_r <= addr_ok && !hwrite;
            if (addr_ok) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_r <= HIGH_RST;
            low_r  <= LOW_RST;
            hyst_r <= HYST_RST;
            mode_r <= 1'b0;
            pol_r  <= 1'b0;
            shdn_r <= 1'b0;
        end else if (wr_pend_r) begin
            unique case (addr_r)
                OFF_HIGH: high_r <= hwdata[TW-1:0];
                OFF_LOW:  low_r  <= hwdata[TW-1:0];
                OFF_HYST: hyst_r <= hwdata[HW-1:0];
                OFF_CTRL: begin
                    mode_r <= hwdata[CTRL_MODE_BIT];
                    pol_r  <= hwdata[CTRL_POL_BIT];
                    shdn_r <= hwdata[CTRL_SHDN_BIT];
                end
                default: ;
            endcase
        end
    end

    assign shdn_nxt = wr_pend_r && (addr_r == OFF_CTRL) && hwdata[CTRL_SHDN_BIT];
    assign rd_done  = rd_pend_r;

    // Read data, registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                OFF_HIGH: rdata_r <= {16'h0000, high_r};
                OFF_LOW:  rdata_r <= {16'h0000, low_r};
                OFF_HYST: rdata_r <= {28'h0000000, hyst_r};
                OFF_CTRL: rdata_r <= {29'h00000000, shdn_r, pol_r, mode_r};
                OFF_STAT: rdata_r <= {30'h00000000, over_hi, alert_r};
                OFF_TEMP: rdata_r <= {16'h0000, temp_r};
                default:  rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_r <= 16'h0000;
            eval_r <= 1'b0;
        end else begin
            eval_r <= temp_valid && !shdn_r;
            if (temp_valid && !shdn_r) begin
                temp_r <= temp_value;
            end
        end
    end

    tla_compare #(
        .TW (TW),
        .HW (HW)
    ) u_cmp (
        .temp     (temp_r),
        .high_lim (high_r),
        .low_lim  (low_r),
        .hyst     (hyst_r),
        .over_hi  (over_hi),
        .under_lo (under_lo),
        .clear_ok (clear_ok)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_r <= 1'b0;
        end else if (mode_r) begin
            if (eval_r && (over_hi || under_lo)) begin
                alert_r <= 1'b1;
            end else if (eval_r && clear_ok) begin
                alert_r <= 1'b0;
            end
        end else begin
            // New event sets, wins over clear
            if (eval_r && (over_hi || under_lo)) begin
                alert_r <= 1'b1;
            end else if (rd_done || shdn_nxt) begin
                alert_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_o_r <= 1'b0;
            oe_n_r    <= 1'b1;
        end else begin
            alert_o_r <= 1'b0;
            oe_n_r    <= ~(alert_r ^ pol_r);
        end
    end

    a_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mode_r && rd_done && !(eval_r && (over_hi || under_lo))) |=> !alert_r)
        else $error("Read did not clear latched alert");

    a_event_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        (eval_r && (over_hi || under_lo)) |=> alert_r)
        else $error("Limit event did not raise alert");

    a_pin_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (oe_n_r == ~($past(alert_r) ^ $past(pol_r))))
        else $error("Alert pin polarity wrong");

    a_cmp_shdn_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_r && !eval_r) |=> $stable(alert_r))
        else $error("Comparator alert changed without result");

    a_shdn_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mode_r && shdn_nxt && !eval_r) |=> !alert_r)
        else $error("Shutdown did not clear latched alert");

    a_latch_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mode_r && !alert_r && !(eval_r && (over_hi || under_lo))) |=> !alert_r)
        else $error("Latched alert rose without event");

    a_cmp_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_r && eval_r && clear_ok && !over_hi && !under_lo) |=> !alert_r)
        else $error("Comparator did not release");

    a_high_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_r && addr_r == OFF_HIGH) |=> (high_r == $past(hwdata[TW-1:0])))
        else $error("Upper limit write lost");
endmodule // tla_top

//--- verif/temperature_limit_alert_test.sv
// Register and alert pin tests for the limit alert block
`timescale 1ns/1ps
module temperature_limit_alert_test;
    import tla_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, temp_valid = 0, pol = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [15:0] temp_value = 0;
    logic        hreadyout, hresp, alert_o, alert_oe_n, pin_level;
    int          failures = 0, n_checks = 0;

    always #25 hclk = ~hclk;

    tla_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .temp_value(temp_value), .temp_valid(temp_valid), .alert_o(alert_o),
        .alert_oe_n(alert_oe_n));
    tla_host_pin host (.alert_o(alert_o), .alert_oe_n(alert_oe_n), .pin_level(pin_level));

    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wt;
        int i;
        @(posedge hclk);
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge hclk);
        if (i == 20) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wt();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic tv(input logic [15:0] v);
        temp_value <= v;
        temp_valid <= 1'b1;
        @(posedge hclk);
        temp_valid <= 1'b0;
    endtask

    task automatic pa(input logic a);
        repeat (3) @(posedge hclk);
        chk({31'h0, pin_level}, {31'h0, ~(a ^ pol)});
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, OFF_HIGH, 0); chk(q, {16'h0, HIGH_RST});
        ahb(0, OFF_LOW, 0); chk(q, {16'h0, LOW_RST});
        ahb(0, OFF_HYST, 0); chk(q, {28'h0, HYST_RST});
        ahb(0, OFF_CTRL, 0); chk(q, 32'h0);
        tv(16'h2000); pa(0);
        tv(16'h2001); pa(1);
        tv(16'h1000); pa(1);
        ahb(0, 8'h40, 0); chk(q, 32'h0);
        pa(0);
        tv(16'h1000); pa(0);
        tv(16'h04ff); pa(1);
        ahb(1, OFF_CTRL, 32'h4); pa(0);
        ahb(1, OFF_CTRL, 32'h1); pa(0);
        tv(16'h2001); pa(1);
        ahb(0, OFF_TEMP, 0); chk(q, 32'h2001);
        pa(1);
        tv(16'h1d80); pa(1);
        tv(16'h1d7f); pa(0);
        tv(16'h8000); pa(1);
        ahb(1, OFF_CTRL, 32'h5); pa(1);
        tv(16'h1000); pa(1);
        ahb(1, OFF_CTRL, 32'h1); tv(16'h0780); pa(1);
        tv(16'h0781); pa(0);
        pol = 1'b1;
        ahb(1, OFF_CTRL, 32'h2); pa(0);
        tv(16'h2001); pa(1);
        ahb(0, OFF_STAT, 0); chk(q, 32'h3); pa(0);
        tv(16'h2001); pa(1);
        ahb(0, OFF_HIGH, 0); chk(q, {16'h0, HIGH_RST}); pa(0);
        ahb(1, OFF_HIGH, 32'h1000); ahb(0, OFF_HIGH, 0); chk(q, 32'h1000);
        hsize <= 3'h0; ahb(1, OFF_HIGH, 32'h0123); hsize <= HSIZE_WORD;
        ahb(0, OFF_HIGH, 0); chk(q, 32'h1000);
        tv(16'h1001); pa(1);
        ahb(1, OFF_LOW, 32'hfff0); ahb(0, OFF_LOW, 0); chk(q, 32'hfff0); pa(0);
        tv(16'hffef); pa(1);
        ahb(1, OFF_HYST, 32'hff); ahb(0, OFF_HYST, 0); chk(q, 32'hf); pa(0);
        give_verdict();
    end
endmodule // temperature_limit_alert_test

//--- verif/tla_host_pin.sv
// Host view of the open-drain alert pin with its pull-up
`timescale 1ns/1ps
module tla_host_pin (
    input  wire logic alert_o,
    input  wire logic alert_oe_n,
    output logic      pin_level
);
    // Pull-up holds the line high once released
    assign pin_level = alert_oe_n ? 1'b1 : alert_o;
endmodule // tla_host_pin
